// ===== hdl/fault_latch_pkg.sv
// Shared constants for the fault-protection latch.
// Assumes a single 100 MHz clock.
`default_nettype none
package fault_latch_pkg;
  localparam int CLK_MHZ = 100;
  // Dead-band times in nanoseconds, as typical figures
  localparam int OVER_TEMP_DEADBAND_NS = 5000;
  localparam int OVER_CURRENT_DEADBAND_NS = 1250;
  localparam int UNDERVOLT_DEADBAND_NS = 1410;
  // Least times, rounded up to whole cycles
  localparam int OVER_TEMP_CYCLES =
    (OVER_TEMP_DEADBAND_NS * CLK_MHZ + 999) / 1000;
  localparam int OVER_CURRENT_CYCLES =
    (OVER_CURRENT_DEADBAND_NS * CLK_MHZ + 999) / 1000;
  localparam int UNDERVOLT_CYCLES =
    (UNDERVOLT_DEADBAND_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 10;
  localparam int NUM_CHANNELS = 2;
  localparam logic LATCH_RESET = 1'b0;
endpackage
`default_nettype wire

// ===== hdl/deadband_filter.sv
// Consecutive-cycle qualifier for one fault condition.
// Assumes the condition input is synchronous to clk.
`default_nettype none
module deadband_filter
#(
  parameter logic [fault_latch_pkg::CNT_W-1:0] LIMIT = 10'h001
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cond,
  output var  logic qualified
);
  import fault_latch_pkg::*;

  logic [CNT_W-1:0] count;

  // Count held condition; a drop restarts from zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (!cond)
      count <= '0;
    else if (count != LIMIT)
      count <= count + 1'b1;
  end

  assign qualified = cond && (count == LIMIT);
endmodule
`default_nettype wire

// ===== hdl/motor_driver_fault_latch.sv
// Fault latch: filters over-temperature, over-current and supply
// under-voltage, forces bridges off, drives open-drain fault flag.
// Assumes comparator inputs and sleep are synchronous to clk.
// Functional notes
// - Filtered over-temperature forces all outputs off
// - Filtered over-current forces outputs off, spikes ignored
// - Any channel over-current disables both channels
// - Temperature and current shutdowns stay latched
// - Latch clears on power-up or on sleep entry
// - Filtered undervoltage forces off, resets internals
// - Lockout releases when supply recovers, no host
// - Fault flag pulls low while shutdown latched
`default_nettype none
module motor_driver_fault_latch
(
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     overTempCmp,
  input  wire logic [fault_latch_pkg::NUM_CHANNELS-1:0] highSideOverCurrent,
  input  wire logic [fault_latch_pkg::NUM_CHANNELS-1:0] lowSideOverCurrent,
  input  wire logic                                     motorSupplyLow,
  input  wire logic                                     motorSupplyRecovered,
  input  wire logic                                     sleepMode,
  output var  logic                                     bridgeEnable,
  output var  logic                                     internalReset,
  output var  logic                                     fault_flag_out_o,
  output var  logic                                     fault_flag_out_oe
);
  import fault_latch_pkg::*;

  logic overTempQual;
  logic overCurrentQual;
  logic uvQual;
  logic anyOverCurrent;
  logic over_temp_shutdown;
  logic over_current_shutdown;
  logic supply_undervoltage_lockout;

  // Either channel, either switch, feeds one shared filter
  assign anyOverCurrent = |highSideOverCurrent | |lowSideOverCurrent;

  deadband_filter #(.LIMIT(CNT_W'(OVER_TEMP_CYCLES))) u_temp (
    .clk       (clk),
    .rst_n     (rst_n),
    .cond      (overTempCmp),
    .qualified (overTempQual)
  );
  deadband_filter #(.LIMIT(CNT_W'(OVER_CURRENT_CYCLES))) u_curr (
    .clk       (clk),
    .rst_n     (rst_n),
    .cond      (anyOverCurrent),
    .qualified (overCurrentQual)
  );
  deadband_filter #(.LIMIT(CNT_W'(UNDERVOLT_CYCLES))) u_uv (
    .clk       (clk),
    .rst_n     (rst_n),
    .cond      (motorSupplyLow),
    .qualified (uvQual)
  );

  // Lockout: set on filtered low, cleared only by recovery level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      supply_undervoltage_lockout <= LATCH_RESET;
    else if (uvQual)
      supply_undervoltage_lockout <= 1'b1;
    else if (motorSupplyRecovered)
      supply_undervoltage_lockout <= 1'b0;
  end

  // Over-temperature latch; sleep or lockout (power-up) clears it,
  // but a fresh detection wins over the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      over_temp_shutdown <= LATCH_RESET;
    else if (overTempQual)
      over_temp_shutdown <= 1'b1;
    else if (sleepMode || supply_undervoltage_lockout)
      over_temp_shutdown <= 1'b0;
  end

  // Over-current latch, same recovery path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      over_current_shutdown <= LATCH_RESET;
    else if (overCurrentQual)
      over_current_shutdown <= 1'b1;
    else if (sleepMode || supply_undervoltage_lockout)
      over_current_shutdown <= 1'b0;
  end

  // Bridge gating is registered so outputs never glitch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridgeEnable  <= 1'b0;
      internalReset <= 1'b1;
    end
    else
    begin
      bridgeEnable  <= !(over_temp_shutdown || over_current_shutdown ||
                         supply_undervoltage_lockout || sleepMode ||
                         overTempQual || overCurrentQual || uvQual);
      internalReset <= supply_undervoltage_lockout || uvQual;
    end
  end

  // Open drain: only ever drives low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_flag_out_oe <= 1'b0;
    else
      fault_flag_out_oe <= over_temp_shutdown || over_current_shutdown;
  end
  assign fault_flag_out_o = 1'b0;

  // Checks
  // Run lengths kept apart from the over-current and over-temperature filters, so
  // a miscount shows as a late latch, or for over-current an early one
  logic [CNT_W-1:0] curRun;
  logic [CNT_W-1:0] tempRun;

  // Consecutive over-current cycles, held at the dead-band limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      curRun <= '0;
    else if (!anyOverCurrent)
      curRun <= '0;
    else if (curRun != CNT_W'(OVER_CURRENT_CYCLES))
      curRun <= curRun + 1'b1;
  end

  // Consecutive over-temperature cycles, held at the limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tempRun <= '0;
    else if (!overTempCmp)
      tempRun <= '0;
    else if (tempRun != CNT_W'(OVER_TEMP_CYCLES))
      tempRun <= tempRun + 1'b1;
  end

  sequence s_curHeld;
    anyOverCurrent [*8];
  endsequence

  property p_offAfterLatch;
    @(posedge clk) disable iff (!rst_n)
      (over_temp_shutdown || over_current_shutdown) |=> !bridgeEnable;
  endproperty
  a_offAfterLatch: assert property (p_offAfterLatch)
    else $error("bridge on while latched");

  property p_curQual;
    @(posedge clk) disable iff (!rst_n)
      (anyOverCurrent && curRun == CNT_W'(OVER_CURRENT_CYCLES))
        |=> over_current_shutdown;
  endproperty
  a_curQual: assert property (p_curQual)
    else $error("over-current not latched");

  property p_spike;
    @(posedge clk) disable iff (!rst_n)
      (!anyOverCurrent ##1 s_curHeld ##1 !anyOverCurrent
       && !over_current_shutdown) |=> !over_current_shutdown;
  endproperty
  a_spike: assert property (p_spike)
    else $error("spike latched");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (over_current_shutdown && !sleepMode &&
       !supply_undervoltage_lockout) |=> over_current_shutdown;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch dropped");

  property p_sleepClr;
    @(posedge clk) disable iff (!rst_n)
      (sleepMode && !overTempQual) |=> !over_temp_shutdown;
  endproperty
  a_sleepClr: assert property (p_sleepClr)
    else $error("sleep did not clear");

  property p_uv;
    @(posedge clk) disable iff (!rst_n)
      uvQual |=> supply_undervoltage_lockout ##1 (internalReset &&
                                                  !bridgeEnable);
  endproperty
  a_uv: assert property (p_uv)
    else $error("lockout missing");

  property p_uvRel;
    @(posedge clk) disable iff (!rst_n)
      (motorSupplyRecovered && !uvQual) |=> !supply_undervoltage_lockout;
  endproperty
  a_uvRel: assert property (p_uvRel)
    else $error("lockout not released");

  property p_flag;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> fault_flag_out_oe ==
        $past(over_temp_shutdown || over_current_shutdown);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag mismatch");

  property p_tempQual;
    @(posedge clk) disable iff (!rst_n)
      (overTempCmp && tempRun == CNT_W'(OVER_TEMP_CYCLES))
        |=> over_temp_shutdown;
  endproperty
  a_tempQual: assert property (p_tempQual)
    else $error("over-temperature not latched");

  property p_qualOff;
    @(posedge clk) disable iff (!rst_n)
      (overTempQual || overCurrentQual || uvQual) |=> !bridgeEnable;
  endproperty
  a_qualOff: assert property (p_qualOff)
    else $error("bridge on after qualified fault");

  // A latch that rises early means the filter skipped a restart
  property p_curEarly;
    @(posedge clk) disable iff (!rst_n)
      $rose(over_current_shutdown) |->
        $past(curRun) == CNT_W'(OVER_CURRENT_CYCLES);
  endproperty
  a_curEarly: assert property (p_curEarly)
    else $error("over-current latched before dead band");
endmodule
`default_nettype wire

// ===== tb/host_model.sv
// Host model: drives sleep, reads the open-drain fault pin.
// Assumes the bench asks for recovery by a one-cycle recover pulse.
`default_nettype none
module host_model #(
  parameter int SLEEP_CYCLES = 150
)
(
  input  wire logic clk,
  input  wire logic recover,
  input  wire logic faultPin,
  output var  logic sleepMode,
  output var  logic faultSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Sleep held past its least width, then left again
  initial
  begin
    sleepMode = 1'b0;
    cnt = 0;
    forever
    begin
      @(posedge clk);
      // Recover is read on the edge, before the bench moves it
      if (recover && cnt == 0)
        cnt = SLEEP_CYCLES;
      #1;
      sleepMode = (cnt > 0);
      if (cnt > 0)
        cnt--;
    end
  end
  // Pulled-up pin reads low only while the device sinks it
  assign faultSeen = (faultPin === 1'b0);
endmodule
`default_nettype wire

// ===== tb/tb_motor_driver_fault_latch.sv
// Bench for the fault latch: row table, then reset and restarts.
// Assumes a pull-up on the fault pin and a host model for sleep.
`default_nettype none
module tb_motor_driver_fault_latch;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_latch_pkg::*;
  typedef struct {logic [5:0] s; int h; logic b; logic f; logic r;} row_t;
  localparam int OT = OVER_TEMP_CYCLES;
  localparam int OC = OVER_CURRENT_CYCLES;
  localparam int UV = UNDERVOLT_CYCLES;
  logic clk = 0, rst_n = 0, recover = 0, sleepMode, faultSeen;
  logic [5:0] cond = 6'h00;
  logic bridgeEnable, internalReset, flagO, flagOe;
  logic midSupply = 0;
  wire logic faultPin;
  int failures = 0, n_tests = 0, cycles = 0;
  // Supply rows keep their bit through the 4-cycle settle step
  row_t rows[9] = '{'{6'h01, OT+2, 0, 1, 0}, '{6'h01, OT-3, 1, 0, 0},
    '{6'h02, OC+2, 0, 1, 0}, '{6'h04, OC+2, 0, 1, 0},
    '{6'h08, OC+2, 0, 1, 0}, '{6'h10, OC+2, 0, 1, 0},
    '{6'h02, OC-3, 1, 0, 0}, '{6'h20, UV+2, 0, 0, 1},
    '{6'h20, UV-5, 1, 0, 0}};
  // Open drain with pull-up: low only while enabled
  assign faultPin = flagOe ? flagO : 1'b1;
  initial
  begin
    forever #5 clk = ~clk;
  end
  motor_driver_fault_latch u_motor_driver_fault_latch (.clk(clk),
    .rst_n(rst_n), .overTempCmp(cond[0]), .highSideOverCurrent(cond[2:1]),
    .lowSideOverCurrent(cond[4:3]), .motorSupplyLow(cond[5]),
    .motorSupplyRecovered(!cond[5] && !midSupply), .sleepMode(sleepMode),
    .bridgeEnable(bridgeEnable), .internalReset(internalReset),
    .fault_flag_out_o(flagO), .fault_flag_out_oe(flagOe));
  host_model u_host_model (.clk(clk), .recover(recover),
    .faultPin(faultPin), .sleepMode(sleepMode), .faultSeen(faultSeen));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    cyc(2);
    check(bridgeEnable, 1'b0);
    check(internalReset, 1'b1);
    check(faultSeen, 1'b0);
    cyc(18);
    rst_n = 1;
    cyc(3);
    // Each row: hold, drop latching sources, check, recover
    foreach (rows[i])
    begin
      cond = rows[i].s;
      cyc(rows[i].h);
      cond = rows[i].s & 6'h20;
      cyc(4);
      check(bridgeEnable, rows[i].b);
      check(faultSeen, rows[i].f);
      check(internalReset, rows[i].r);
      cond = 6'h00;
      recover = rows[i].f;
      cyc(1);
      recover = 0;
      cyc(rows[i].f ? 160 : 4);
      check(bridgeEnable, 1'b1);
      check(faultSeen, 1'b0);
      check(internalReset, 1'b0);
    end
    // Dropout of one cycle restarts the count
    cond = 6'h02;
    cyc(OC-3);
    cond = 6'h00;
    cyc(1);
    cond = 6'h02;
    cyc(OC-3);
    cond = 6'h00;
    cyc(4);
    check(bridgeEnable, 1'b1);
    // Eight-cycle spike on one switch must not trip
    cond = 6'h04;
    cyc(8);
    cond = 6'h00;
    cyc(4);
    check(bridgeEnable, 1'b1);
    // Supply between entry and recovery levels keeps the lockout
    cond = 6'h20;
    cyc(UV+2);
    cond = 6'h00;
    midSupply = 1;
    cyc(4);
    check(bridgeEnable, 1'b0);
    check(internalReset, 1'b1);
    midSupply = 0;
    cyc(4);
    check(bridgeEnable, 1'b1);
    check(internalReset, 1'b0);
    // Latched trip cleared by a second reset in mid-run
    cond = 6'h01;
    cyc(OT+2);
    cond = 6'h00;
    cyc(4);
    check(faultSeen, 1'b1);
    rst_n = 0;
    cyc(2);
    check(faultSeen, 1'b0);
    check(bridgeEnable, 1'b0);
    rst_n = 1;
    cyc(4);
    check(bridgeEnable, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
